//--- inc/ppm_pkg.sv
// Constants shared by the port pattern-match interrupt block
package ppm_pkg;
	// ****************************************
	// Port and bus widths
	// ****************************************
	localparam int PORT_W_DEF = 8;
	localparam int ADR_W = 5;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [ADR_W-1:0] OFS_MASK = 5'h00;
	localparam logic [ADR_W-1:0] OFS_PATN = 5'h04;
	localparam logic [ADR_W-1:0] OFS_CTRL = 5'h08;
	localparam logic [ADR_W-1:0] OFS_STAT = 5'h0c;
	localparam logic [ADR_W-1:0] OFS_IEN = 5'h10;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTRL_FLAG = 0;
	localparam int CTRL_SENSE = 1;
	localparam int CTRL_ACTIVE = 2;

	// ****************************************
	// Status and interrupt-enable fields
	// ****************************************
	localparam int STAT_W = 2;
	localparam int ST_MATCH = 0;
	localparam int ST_WAKE = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_PATN = 8'hff;
	localparam logic RST_SENSE = 1'b0;
	localparam logic RST_ACTIVE = 1'b0;
	localparam logic [STAT_W-1:0] RST_STAT = 2'h0;
	localparam logic [STAT_W-1:0] RST_IEN = 2'h0;

	// ****************************************
	// Timing in cpu_core_clock cycles
	// ****************************************
	localparam int HOLD_CYC = 6;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] HOLD_CNT = 3'h6;
endpackage

//--- rtl/ppm_hold_filter.sv
// Persistence filter: qualifies a condition held longer than the hold count
`timescale 1ns/1ns
module ppm_hold_filter
	import ppm_pkg::*;
(
	input wire logic clock_i, // Core clock
	input wire logic nrst_i, // Synchronous reset, active low
	input wire logic ce_i, // Clock enable
	input wire logic cond_i, // Raw match condition
	output logic qual_o // Condition held past the hold count
);
	logic [CNT_W-1:0] run_cnt;

	// ****************************************
	// Run-length counter
	// ****************************************
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			run_cnt <= '0;
		else if (ce_i)
		begin
			if (!cond_i)
				run_cnt <= '0;
			else if (run_cnt != HOLD_CNT)
				run_cnt <= run_cnt + 3'h1;
		end
	end

	// Seventh straight cycle of the condition qualifies
	assign qual_o = cond_i && (run_cnt == HOLD_CNT);

	a_hold_count: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		qual_o |-> $past(cond_i, 1) && $past(cond_i, 6))
		else $error("qualified before condition held long enough");
endmodule

//--- rtl/ppm_top.sv
// Port pattern-match interrupt unit with classic Wishbone register slave
`timescale 1ns/1ns
module ppm_top
	import ppm_pkg::*;
#(
	parameter int PORT_W = PORT_W_DEF
)
(
	input wire logic clock_i, // Core clock, 100 MHz
	input wire logic nrst_i, // Synchronous reset, active low
	input wire logic ce_i, // Clock enable, freezes state when low
	input wire logic [PORT_W-1:0] port_i, // Watched port pins
	input wire logic idle_i, // Core is in idle mode
	input wire logic pdown_i, // Core is in power-down mode
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [ADR_W-1:0] wb_adr_i, // Wishbone byte address
	input wire logic [SEL_W-1:0] wb_sel_i, // Wishbone byte selects
	input wire logic [DAT_W-1:0] wb_dat_i, // Wishbone write data
	output logic [DAT_W-1:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	output logic irq_o, // Interrupt request, level
	output logic wake_o // Wake request to the power controller
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [PORT_W-1:0] port_meta;
	logic [PORT_W-1:0] port_sync;
	logic [PORT_W-1:0] pin_participation_mask;
	logic [PORT_W-1:0] match_pattern_value;
	logic compare_sense_select;
	logic match_active;
	logic match_flag;
	logic [STAT_W-1:0] stat;
	logic [STAT_W-1:0] ien;
	logic [STAT_W-1:0] next_stat;
	logic next_flag;
	logic bus_req;
	logic wr_stb;
	logic rd_stb;
	logic lane0_wr;
	logic port_equal;
	logic match_cond;
	logic match_qual;
	logic sleeping;
	logic flag_clear;
	logic [STAT_W-1:0] stat_clear;
	logic [STAT_W-1:0] stat_set;
	logic [DAT_W-1:0] next_rdata;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
		hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
	endfunction

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_stb = bus_req && wb_we_i && ce_i;
	assign rd_stb = bus_req && !wb_we_i && ce_i;
	assign lane0_wr = wr_stb && wb_sel_i[0];

	// ****************************************
	// Port synchroniser
	// ****************************************
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			port_meta <= '0;
			port_sync <= '0;
		end
		else if (ce_i)
		begin
			port_meta <= port_i;
			port_sync <= port_meta;
		end
	end

	// ****************************************
	// Mask and pattern registers
	// ****************************************
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			pin_participation_mask <= PORT_W'(RST_MASK);
		else if (lane0_wr && hit(wb_adr_i, OFS_MASK))
			pin_participation_mask <= wb_dat_i[PORT_W-1:0];
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			match_pattern_value <= PORT_W'(RST_PATN);
		else if (lane0_wr && hit(wb_adr_i, OFS_PATN))
			match_pattern_value <= wb_dat_i[PORT_W-1:0];
	end

	// ****************************************
	// Control and interrupt-enable register settings
	// ****************************************
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			compare_sense_select <= RST_SENSE;
			match_active <= RST_ACTIVE;
		end
		else if (lane0_wr && hit(wb_adr_i, OFS_CTRL))
		begin
			compare_sense_select <= wb_dat_i[CTRL_SENSE];
			match_active <= wb_dat_i[CTRL_ACTIVE];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			ien <= RST_IEN;
		else if (lane0_wr && hit(wb_adr_i, OFS_IEN))
			ien <= wb_dat_i[STAT_W-1:0];
	end

	// ****************************************
	// Pattern compare
	// ****************************************
	// Pins outside the mask never differ
	assign port_equal = (((port_sync ^ match_pattern_value) & pin_participation_mask) == '0);
	assign match_cond = match_active && (compare_sense_select ? !port_equal : port_equal);

	ppm_hold_filter u_filter
	(
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.cond_i(match_cond),
		.qual_o(match_qual)
	);

	// ****************************************
	// Match flag
	// ****************************************
	// Either register's clear bit drops the flag
	assign flag_clear = lane0_wr && ((hit(wb_adr_i, OFS_CTRL) && wb_dat_i[CTRL_FLAG])
		|| (hit(wb_adr_i, OFS_STAT) && wb_dat_i[ST_MATCH]));
	// Set wins over a simultaneous clear
	assign next_flag = match_qual || (match_flag && !flag_clear);

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			match_flag <= 1'b0;
		else if (ce_i)
			match_flag <= next_flag;
	end

	// ****************************************
	// Status, interrupt and wake
	// ****************************************
	assign sleeping = idle_i || pdown_i;
	assign stat_set = {match_qual && sleeping, next_flag};
	assign stat_clear = (lane0_wr && hit(wb_adr_i, OFS_STAT)) ? wb_dat_i[STAT_W-1:0] : '0;

	always_comb
	begin
		next_stat = stat_set | (stat & ~stat_clear);
		// Match bit follows the flag, whichever register clears it
		next_stat[ST_MATCH] = next_flag && !(stat_clear[ST_MATCH] && !match_qual);
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			stat <= RST_STAT;
		else if (ce_i)
			stat <= next_stat;
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= |(next_stat & ien);
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			wake_o <= 1'b0;
		else if (ce_i)
			wake_o <= sleeping && next_stat[ST_MATCH] && ien[ST_MATCH];
	end

	// ****************************************
	// Wishbone read and acknowledge
	// ****************************************
	always_comb
	begin
		next_rdata = '0;
		if (hit(wb_adr_i, OFS_MASK))
			next_rdata[PORT_W-1:0] = pin_participation_mask;
		else if (hit(wb_adr_i, OFS_PATN))
			next_rdata[PORT_W-1:0] = match_pattern_value;
		else if (hit(wb_adr_i, OFS_CTRL))
		begin
			next_rdata[CTRL_FLAG] = match_flag;
			next_rdata[CTRL_SENSE] = compare_sense_select;
			next_rdata[CTRL_ACTIVE] = match_active;
		end
		else if (hit(wb_adr_i, OFS_STAT))
			next_rdata[STAT_W-1:0] = stat;
		else if (hit(wb_adr_i, OFS_IEN))
			next_rdata[STAT_W-1:0] = ien;
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			wb_dat_o <= '0;
		else if (rd_stb)
			wb_dat_o <= next_rdata;
	end

	// Every address answers; unmapped reads return zero
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			wb_ack_o <= 1'b0;
		else if (ce_i)
			wb_ack_o <= bus_req;
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_all_high_pattern;
		match_active && compare_sense_select && (match_pattern_value == '1)
			&& ((~port_sync & pin_participation_mask) != '0);
	endsequence

	sequence s_pin_low_held;
		s_all_high_pattern [*7];
	endsequence

	sequence s_flag_no_clear;
		match_flag && !flag_clear;
	endsequence

	a_mask_excludes_pins: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(pin_participation_mask == '0) && match_active && !compare_sense_select |-> match_cond)
		else $error("empty mask did not give equal");

	a_pattern_compare: assert property (@(posedge clock_i) disable iff (!nrst_i)
		match_active && !compare_sense_select && (port_sync == match_pattern_value) |-> match_cond)
		else $error("equal port not seen as match");

	a_sense_select: assert property (@(posedge clock_i) disable iff (!nrst_i)
		match_active |-> (match_cond == (compare_sense_select ^ port_equal)))
		else $error("compare sense wrong");

	a_flag_sets: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		match_qual |=> match_flag)
		else $error("qualified match did not set flag");

	a_irq_gated: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		match_flag && !flag_clear && ien[ST_MATCH] |=> irq_o)
		else $error("enabled flag gave no interrupt");

	a_irq_quiet: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		(ien == '0) |=> !irq_o)
		else $error("interrupt with all enables off");

	a_key_press: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		s_pin_low_held |=> match_flag)
		else $error("pin low did not set flag");

	a_wake_core: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		match_flag && !flag_clear && ien[ST_MATCH] && sleeping |=> wake_o)
		else $error("no wake from sleep");

	a_short_ignored: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		!match_cond ##1 match_cond [*6] ##1 !match_cond |-> !match_qual && $past(!match_qual))
		else $error("short condition qualified");

	a_flag_sticky: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		s_flag_no_clear |=> match_flag)
		else $error("flag dropped without clear");

	a_ack_one_cycle: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	a_ack_answers: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		bus_req |=> wb_ack_o)
		else $error("request not acknowledged");

	a_clear_drops_flag: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		flag_clear && !match_qual |=> !match_flag)
		else $error("flag survived a clear");

	a_stat_tracks_flag: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		stat[ST_MATCH] == match_flag)
		else $error("status match bit differs from flag");

	a_inactive_quiet: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		!match_active |-> !match_cond)
		else $error("condition while function inactive");

	a_mask_write: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		lane0_wr && hit(wb_adr_i, OFS_MASK) |=> pin_participation_mask == $past(wb_dat_i[PORT_W-1:0]))
		else $error("mask write lost");

	a_pattern_write: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		lane0_wr && hit(wb_adr_i, OFS_PATN) |=> match_pattern_value == $past(wb_dat_i[PORT_W-1:0]))
		else $error("pattern write lost");

	a_ien_write: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		lane0_wr && hit(wb_adr_i, OFS_IEN) |=> ien == $past(wb_dat_i[STAT_W-1:0]))
		else $error("enable write lost");

	a_wake_event_set: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		match_qual && sleeping |=> stat[ST_WAKE])
		else $error("wake event not recorded");

	a_wake_asleep_only: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		!sleeping |=> !wake_o)
		else $error("wake while awake");

	a_irq_from_wake: assert property (@(posedge clock_i) disable iff (!nrst_i || !ce_i)
		stat[ST_WAKE] && ien[ST_WAKE] && !stat_clear[ST_WAKE] |=> irq_o)
		else $error("enabled wake event gave no interrupt");
endmodule

//--- tb/ppm_keypad_model.sv
// Keypad model: switches to ground with pull-ups on the watched pins
`timescale 1ns/1ns
module ppm_keypad_model
(
	input wire logic clock_i, // Core clock
	input wire logic [7:0] keys_i, // Keys held down, high when pressed
	output logic [7:0] port_o // Pin levels seen by the block
);
	// Released keys float high through the pull-ups
	always_ff @(posedge clock_i)
	begin
		port_o <= ~keys_i;
	end
endmodule

//--- tb/port_pattern_match_interrupt_test.sv
// Self-checking testbench for the port pattern-match interrupt unit
`timescale 1ns/1ns
module port_pattern_match_interrupt_test;
	import ppm_pkg::*;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic idle = 1'b0;
	logic pdown = 1'b0;
	logic ce = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [4:0] wb_adr = 5'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [7:0] keys = 8'h00;
	logic [7:0] port;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_o;
	logic wake_o;
	logic [31:0] rdat;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;

	always #5 clock_i = ~clock_i;

	ppm_keypad_model ppm_keypad_model_i (.clock_i(clock_i), .keys_i(keys), .port_o(port));

	ppm_top ppm_top_i (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .port_i(port), .idle_i(idle),
		.pdown_i(pdown), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
		.wake_o(wake_o));

	// ****************************************
	// Shared tasks
	// ****************************************
	task complete_run;
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat <= d;
		// Only the ack or the run timeout ends this wait
		do
		begin
			@(posedge clock_i);
		end
		while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clock_i);
	endtask

	task rd(input logic [4:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask

	// Holds keys for n cycles, then lets the sync and filter settle
	task press(input logic [7:0] k, input int n);
		keys <= k;
		repeat (n) @(posedge clock_i);
		keys <= 8'h00;
		repeat (4) @(posedge clock_i);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		rd(OFS_MASK, 32'h0);
		rd(OFS_PATN, 32'hff);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_STAT, 32'h0);
		rd(OFS_IEN, 32'h0);
		rd(5'h14, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
	endtask

	task t_filter;
		wb(1'b1, OFS_MASK, 32'hff);
		wb(1'b1, OFS_CTRL, 32'h6);
		press(8'h01, 6);
		rd(OFS_CTRL, 32'h6);
		press(8'h01, 12);
		rd(OFS_CTRL, 32'h7);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b1, OFS_CTRL, 32'h7);
		rd(OFS_CTRL, 32'h6);
		wb(1'b1, OFS_IEN, 32'h1);
		press(8'h80, 12);
		chk({31'h0, irq_o}, 32'h1);
		wb(1'b1, OFS_STAT, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
	endtask

	task t_mask;
		wb(1'b1, OFS_MASK, 32'h0f);
		press(8'hf0, 12);
		rd(OFS_CTRL, 32'h6);
		press(8'h08, 12);
		rd(OFS_CTRL, 32'h7);
		wb(1'b1, OFS_CTRL, 32'h7);
		// Empty mask always equal; a held match beats a clear
		wb(1'b1, OFS_MASK, 32'h00);
		wb(1'b1, OFS_CTRL, 32'h4);
		repeat (10) @(posedge clock_i);
		rd(OFS_CTRL, 32'h5);
		wb(1'b1, OFS_CTRL, 32'h5);
		rd(OFS_CTRL, 32'h5);
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b1, OFS_CTRL, 32'h1);
		rd(OFS_CTRL, 32'h0);
	endtask

	task t_equal;
		wb(1'b1, OFS_MASK, 32'hff);
		wb(1'b1, OFS_PATN, 32'h5a);
		wb(1'b1, OFS_CTRL, 32'h4);
		rd(OFS_CTRL, 32'h4);
		press(8'ha5, 12);
		rd(OFS_CTRL, 32'h5);
		wb(1'b1, OFS_CTRL, 32'h1);
		press(8'ha5, 12);
		rd(OFS_CTRL, 32'h0);
	endtask

	task t_wake;
		int i;
		wb(1'b1, OFS_PATN, 32'hff);
		wb(1'b1, OFS_CTRL, 32'h6);
		for (i = 0; i < 2; i++)
		begin
			idle <= (i == 0);
			pdown <= (i == 1);
			press(8'h02, 12);
			chk({31'h0, wake_o}, 32'h1);
			rd(OFS_STAT, 32'h3);
			wb(1'b1, OFS_STAT, 32'h3);
			chk({31'h0, wake_o}, 32'h0);
		end
		idle <= 1'b0;
		pdown <= 1'b0;
	endtask

	// Frozen clock enable counts no port activity
	task t_freeze;
		ce <= 1'b0;
		press(8'h01, 12);
		ce <= 1'b1;
		rd(OFS_CTRL, 32'h6);
		press(8'h01, 12);
		rd(OFS_CTRL, 32'h7);
	endtask

	// ****************************************
	// Run control
	// ****************************************
	always @(posedge clock_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			complete_run;
		end
	end

	initial
	begin
		repeat (16) @(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_reset;
		t_filter;
		t_mask;
		t_equal;
		t_wake;
		t_freeze;
		complete_run;
	end
endmodule
